// ==== host_serial_master.sv ====
// Host serial master driving select and shift clock
`timescale 1ns/100ps
`default_nettype none
module host_serial_master (
  // Pins toward the device
  output var logic conv_sel_n,
  output var logic shift_clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  localparam int HALF = 32;
  logic last = 1'b0;
  logic line;
  logic end_oe = 1'b0;
  bit got[$];
  initial
  begin
    conv_sel_n = 1'b1;
    shift_clk = 1'b0;
  end
  always @(serial_result_out or serial_result_oe)
    if (serial_result_oe)
      last = serial_result_out;
  // Released line shows no stale value
  assign line = serial_result_oe ? serial_result_out : ~last;
  // Burst clock confined to the frame
  task automatic frame(input bit idle_hi, input int falls);
    got = {};
    shift_clk = idle_hi;
    #(HALF);
    conv_sel_n = 1'b0;
    #(HALF);
    for (int i = 0; i < falls; i++)
    begin
      if (!idle_hi)
      begin
        shift_clk = 1'b1;
        got.push_back(line);
        #(HALF);
      end
      shift_clk = 1'b0;
      #(HALF);
      if (idle_hi && i < falls - 1)
      begin
        shift_clk = 1'b1;
        got.push_back(line);
        #(HALF);
      end
    end
    end_oe = serial_result_oe;
    // Select held low past the fourteenth fall unless cut short
    conv_sel_n = 1'b1;
    #(HALF);
    shift_clk = idle_hi;
  endtask
  // Select pulse with shift clock static
  task automatic pulse();
    conv_sel_n = 1'b0;
    #(2 * HALF);
    conv_sel_n = 1'b1;
    #(2 * HALF);
  endtask
endmodule
`default_nettype wire

// ==== pin_edge_sync.sv ====
// Three-stage pin synchroniser with edge pulses
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sync
  import sar_readout_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and result
  input wire logic pin,
  output var pin_edge_t sync
);
  logic s1;
  logic s2;
  logic s3;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1 <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Change accepted once stages two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync <= '{level: RESET_LEVEL, rise: 1'b0, fall: 1'b0};
    end
    else
    begin
      sync.rise <= (s2 == s3) && s3 && !sync.level;
      sync.fall <= (s2 == s3) && !s3 && sync.level;
      if (s2 == s3)
      begin
        sync.level <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sar_readout_pkg.sv ====
// Shared constants and types for the serial conversion readout block
package sar_readout_pkg;
  localparam int RESULT_BITS = 14;
  localparam int FRAME_BITS = 16;
  localparam int CONV_STEPS = 14;
  localparam int NAP_PULSES = 2;
  localparam int SLEEP_PULSES = 4;
  localparam int CLK_PERIOD_NS = 5;
  localparam int NAP_WAKE_NS = 50;
  localparam real SLEEP_WAKE_MS = 1.1;
  localparam int NAP_WAKE_CYCLES = (NAP_WAKE_NS / CLK_PERIOD_NS < 1) ? 1 : NAP_WAKE_NS / CLK_PERIOD_NS;
  localparam int SLEEP_WAKE_CYCLES = int'(SLEEP_WAKE_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam logic [4:0] BIT_CNT_RESET = 5'h00;
  localparam logic [2:0] PULSE_CNT_RESET = 3'h0;
  localparam logic [13:0] RESULT_RESET = 14'h0000;

  typedef logic [RESULT_BITS-1:0] result_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } pin_edge_t;

  typedef enum logic [3:0] {
    PWR_ACTIVE = 4'b0001,
    PWR_NAP = 4'b0010,
    PWR_SLEEP = 4'b0100,
    PWR_WAKING = 4'b1000
  } power_state_t;
endpackage

// ==== sar_serial_readout.sv ====
// Serial conversion and readout logic of the sampling converter
`timescale 1ns/100ps
`default_nettype none
module sar_serial_readout
  import sar_readout_pkg::*;
#(
  parameter int SLEEP_WAKE = SLEEP_WAKE_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic conv_sel_n,
  input wire logic shift_clk,
  output logic serial_result_out,
  output logic serial_result_oe,
  // Analog front end
  input wire result_t sample_in,
  output logic tracking,
  output logic bias_on,
  // Power status
  output logic nap,
  output logic sleep,
  output logic ready,
  output logic result_suspect
);
  pin_edge_t sel;
  pin_edge_t sck;
  power_state_t pwr;
  power_state_t next_pwr;
  logic [FRAME_BITS-1:0] shreg;
  logic [4:0] bit_cnt;
  logic [2:0] pulse_cnt;
  logic [17:0] wake_cnt;
  logic in_frame;
  logic frame_clocked;
  result_t held;
  result_t result;
  logic clocked_close;
  logic static_close;

  pin_edge_sync #(.RESET_LEVEL(1'b1)) sel_sync (.clk(clk), .rst(rst), .pin(conv_sel_n), .sync(sel));
  pin_edge_sync #(.RESET_LEVEL(1'b0)) sck_sync (.clk(clk), .rst(rst), .pin(shift_clk), .sync(sck));

  assign clocked_close = sel.rise && frame_clocked;
  assign static_close = sel.rise && !frame_clocked;

  // Frame bookkeeping and hold capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      in_frame <= 1'b0;
      frame_clocked <= 1'b0;
      held <= RESULT_RESET;
    end
    else if (sel.fall)
    begin
      in_frame <= 1'b1;
      frame_clocked <= 1'b0;
      held <= sample_in;
    end
    else if (sel.rise)
    begin
      in_frame <= 1'b0;
    end
    else if (in_frame && (sck.rise || sck.fall))
    begin
      frame_clocked <= 1'b1;
    end
  end

  // Sample-and-hold tracks while select is high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tracking <= 1'b1;
    end
    else
    begin
      tracking <= sel.level;
    end
  end

  // Conversion steps; result lands on the fourteenth falling edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt <= BIT_CNT_RESET;
      result <= RESULT_RESET;
    end
    else if (sel.fall)
    begin
      bit_cnt <= BIT_CNT_RESET;
    end
    else if (in_frame && sck.fall && bit_cnt != 5'(FRAME_BITS))
    begin
      bit_cnt <= bit_cnt + 5'h01;
      if (bit_cnt == 5'(CONV_STEPS - 1))
      begin
        result <= held;
      end
    end
  end

  // Output shift register, MSB first with leading zeros
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shreg <= '0;
    end
    else if (sel.fall)
    begin
      shreg <= sck.level ? {2'b00, result} : {1'b0, result, 1'b0};
    end
    else if (in_frame && sck.fall)
    begin
      shreg <= {shreg[FRAME_BITS-2:0], 1'b0};
    end
  end

  // Output drive and enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      serial_result_out <= 1'b0;
      serial_result_oe <= 1'b0;
    end
    else if (sel.level && !sel.fall)
    begin
      serial_result_oe <= 1'b0;
      serial_result_out <= 1'b0;
    end
    else if (sel.fall)
    begin
      serial_result_oe <= 1'b1;
      serial_result_out <= 1'b0;
    end
    else if (in_frame && sck.fall)
    begin
      serial_result_out <= shreg[FRAME_BITS-2];
      if (bit_cnt == 5'(FRAME_BITS - 1))
      begin
        serial_result_oe <= 1'b0;
      end
    end
  end

  // Static select pulses count toward power-down
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pulse_cnt <= PULSE_CNT_RESET;
    end
    else if (clocked_close)
    begin
      pulse_cnt <= PULSE_CNT_RESET;
    end
    else if (static_close && pulse_cnt != 3'(SLEEP_PULSES))
    begin
      pulse_cnt <= pulse_cnt + 3'h1;
    end
  end

  // Power state
  always_comb
  begin
    next_pwr = pwr;
    unique case (pwr)
      PWR_ACTIVE, PWR_WAKING:
      begin
        if (static_close && pulse_cnt == 3'(NAP_PULSES - 1))
        begin
          next_pwr = PWR_NAP;
        end
        else if (pwr == PWR_WAKING && wake_cnt == 18'h00000)
        begin
          next_pwr = PWR_ACTIVE;
        end
      end
      PWR_NAP:
      begin
        if (static_close && pulse_cnt == 3'(SLEEP_PULSES - 1))
        begin
          next_pwr = PWR_SLEEP;
        end
        else if (clocked_close)
        begin
          next_pwr = PWR_WAKING;
        end
      end
      PWR_SLEEP:
      begin
        if (clocked_close)
        begin
          next_pwr = PWR_WAKING;
        end
      end
      default:
      begin
        next_pwr = PWR_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pwr <= PWR_ACTIVE;
    end
    else
    begin
      pwr <= next_pwr;
    end
  end

  // Wake timer: short from nap, long from sleep
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wake_cnt <= '0;
    end
    else if (pwr == PWR_NAP && next_pwr == PWR_WAKING)
    begin
      wake_cnt <= 18'(NAP_WAKE_CYCLES - 1);
    end
    else if (pwr == PWR_SLEEP && next_pwr == PWR_WAKING)
    begin
      wake_cnt <= 18'(SLEEP_WAKE - 1);
    end
    else if (wake_cnt != 18'h00000)
    begin
      wake_cnt <= wake_cnt - 18'h00001;
    end
  end

  // Status outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nap <= 1'b0;
      sleep <= 1'b0;
      bias_on <= 1'b1;
      ready <= 1'b1;
      result_suspect <= 1'b0;
    end
    else
    begin
      nap <= next_pwr == PWR_NAP;
      sleep <= next_pwr == PWR_SLEEP;
      bias_on <= next_pwr != PWR_SLEEP;
      ready <= next_pwr == PWR_ACTIVE;
      if (next_pwr == PWR_WAKING && pwr != PWR_WAKING)
      begin
        result_suspect <= 1'b1;
      end
      else if (clocked_close)
      begin
        result_suspect <= 1'b0;
      end
    end
  end

  localparam int nap_wait_max = NAP_WAKE_CYCLES + 1;

  sequence frame_open_s;
    sel.fall;
  endsequence

  sequence two_static_pulses_s;
    static_close && pulse_cnt == 3'(NAP_PULSES - 1) && pwr == PWR_ACTIVE;
  endsequence

  drive_on_fall_a: assert property (@(posedge clk) disable iff (rst) frame_open_s |=> serial_result_oe && !serial_result_out)
    else $error("output not driven low after select fell");
  hiz_sel_high_a: assert property (@(posedge clk) disable iff (rst) sel.level |=> !serial_result_oe)
    else $error("output driven while select high");
  release_after_16_a: assert property (@(posedge clk) disable iff (rst)
    in_frame && sck.fall && bit_cnt == 5'(FRAME_BITS - 1) && !sel.rise |=> !serial_result_oe)
    else $error("output not released after sixteenth edge");
  change_on_fall_a: assert property (@(posedge clk) disable iff (rst)
    !sck.fall && !sel.fall && serial_result_oe |=> $stable(serial_result_out) || !serial_result_oe)
    else $error("output changed without falling shift edge");
  msb_first_a: assert property (@(posedge clk) disable iff (rst)
    in_frame && sck.fall && !sel.level |=> serial_result_out == $past(shreg[FRAME_BITS-2]))
    else $error("wrong bit shifted out");
  latency_a: assert property (@(posedge clk) disable iff (rst)
    in_frame && sck.fall && bit_cnt == 5'(CONV_STEPS - 1) && !sel.fall |=> result == $past(held))
    else $error("conversion result not stored");
  track_a: assert property (@(posedge clk) disable iff (rst) sel.rise |=> tracking ##1 tracking)
    else $error("sampler not tracking after select rose");
  nap_entry_a: assert property (@(posedge clk) disable iff (rst) two_static_pulses_s |=> nap && !ready)
    else $error("nap not entered after two pulses");
  sleep_bias_a: assert property (@(posedge clk) disable iff (rst) sleep |-> !bias_on && !ready)
    else $error("bias on during sleep");
  nap_wake_a: assert property (@(posedge clk) disable iff (rst)
    pwr == PWR_NAP && clocked_close |-> ##[1:nap_wait_max] ready)
    else $error("not ready soon after nap");
endmodule
`default_nettype wire

// ==== sar_serial_readout_test.sv ====
// Self-checking bench of the serial conversion readout block
`timescale 1ns/100ps
`default_nettype none
module sar_serial_readout_test;
  import sar_readout_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  result_t sample_in = '0;
  result_t stored = '0;
  logic conv_sel_n, shift_clk, serial_result_out, serial_result_oe;
  logic tracking, bias_on, nap, sleep, ready, result_suspect;
  int err_count = 0;
  int total_checks = 0;
  initial forever #2.5 clk = ~clk;
  host_serial_master host (.conv_sel_n(conv_sel_n), .shift_clk(shift_clk),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));
  sar_serial_readout #(.SLEEP_WAKE(50)) uut (.clk(clk), .rst(rst), .conv_sel_n(conv_sel_n),
    .shift_clk(shift_clk), .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .sample_in(sample_in), .tracking(tracking), .bias_on(bias_on), .nap(nap), .sleep(sleep),
    .ready(ready), .result_suspect(result_suspect));
  task automatic wrap_up();
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic seen, input logic want);
    total_checks++;
    if (seen !== want)
    begin
      err_count++;
      $display("MISMATCH at %0t: seen %b want %b", $time, seen, want);
    end
  endtask
  task automatic wait_ready(input int lim);
    int c;
    c = 0;
    while (ready !== 1'b1 && c < lim)
    begin
      @(negedge clk);
      c++;
    end
    if (ready !== 1'b1)
    begin
      err_count++;
      $display("MISMATCH at %0t: ready not seen in time", $time);
      wrap_up();
    end
  endtask
  // One frame, bits compared with the model's stored result
  task automatic data_frame(input bit idle_hi, input int falls);
    int n;
    logic want;
    @(negedge clk);
    sample_in = result_t'($urandom);
    fork
      host.frame(idle_hi, falls);
      begin
        #100;
        check(tracking, 1'b0);
        check(serial_result_oe, 1'b1);
      end
    join
    check(host.end_oe, (falls >= FRAME_BITS) ? 1'b0 : 1'b1);
    check(host.got.size() == falls - idle_hi, 1'b1);
    n = (falls > 16 ? 16 : falls) - idle_hi;
    for (int j = 0; j < n; j++)
    begin
      want = (j >= 1 && j <= RESULT_BITS) ? stored[RESULT_BITS - j] : 1'b0;
      check(host.got[j], want);
    end
    if (falls >= 14)
      stored = sample_in;
    check(serial_result_oe, 1'b0);
    check(tracking, 1'b1);
  endtask
  initial
  begin
    #400000;
    err_count++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(32'h059a165b));
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check(ready, 1'b1);
    check(serial_result_oe, 1'b0);
    for (int k = 0; k < 4; k++)
      data_frame(k[0], 16 + k[1]);
    data_frame(1'b0, 5);
    data_frame(1'b1, 16);
    repeat (2) host.pulse();
    check(nap, 1'b1);
    check(ready, 1'b0);
    data_frame(1'b0, 16);
    check(nap, 1'b0);
    check(result_suspect, 1'b1);
    check(ready, 1'b0);
    wait_ready(12);
    data_frame(1'b1, 16);
    check(result_suspect, 1'b0);
    repeat (4) host.pulse();
    check(sleep, 1'b1);
    check(bias_on, 1'b0);
    data_frame(1'b0, 16);
    check(sleep, 1'b0);
    repeat (40) @(negedge clk);
    check(ready, 1'b0);
    wait_ready(30);
    check(bias_on, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
